// ===== common/sgcr_pkg.sv
package sgcr_pkg;
	localparam logic [7:0] GC1_OFFSET = 8'h03;
	localparam logic [7:0] GC2_OFFSET = 8'h04;

	// Control one field positions
	localparam int GC1_AGING_BIT   = 2;
	localparam int GC1_FASTAGE_BIT = 1;
	localparam int GC1_BACKOFF_BIT = 0;
	// Control two field positions
	localparam int GC2_VLANDISC_BIT = 7;
	localparam int GC2_STORMDIS_BIT = 6;
	localparam int GC2_BPMODE_BIT   = 5;
	localparam int GC2_FAIR_BIT     = 4;
	localparam int GC2_NOCOLDROP_BIT = 3;
	localparam int GC2_HUGE_BIT     = 2;
	localparam int GC2_LEGALMAX_BIT = 1;

	// Values before straps are taken: the pads' own pulls
	localparam logic [7:0] GC1_RESET = 8'h04;
	localparam logic [7:0] GC2_RESET = 8'hf0;

	// Strap vector order
	localparam int STRAP_AGING   = 0;
	localparam int STRAP_BACKOFF = 1;
	localparam int STRAP_COLDROP = 2;
	localparam int STRAP_MAXSIZE = 3;
	localparam int STRAP_COUNT   = 4;
	localparam logic [3:0] STRAP_SETTLE_CYCLES = 4'h4;

	localparam logic [10:0] HUGE_MAX_BYTES     = 11'd1916;
	localparam logic [10:0] LEGAL_MAX_BYTES    = 11'd1536;
	localparam logic [10:0] TAGGED_MAX_BYTES   = 11'd1522;
	localparam logic [10:0] UNTAGGED_MAX_BYTES = 11'd1518;
	localparam logic [4:0]  EXCESS_COL_LIMIT   = 5'd16;

	localparam int CORE_CLK_HZ     = 40_000_000;
	localparam int FAST_AGE_US     = 800;
	localparam int FAST_AGE_CYCLES = FAST_AGE_US * (CORE_CLK_HZ / 1_000_000);
	localparam int MS_CYCLES       = CORE_CLK_HZ / 1000;
	localparam int NORMAL_AGE_S    = 300;
	localparam int NORMAL_AGE_MS   = NORMAL_AGE_S * 1000;

	typedef enum logic [1:0] {
		SGCR_SETTLE = 2'b01,
		SGCR_RUN    = 2'b10
	} sgcr_strap_state_t;
endpackage

// ===== core/sgcr_global_ctrl.sv
`timescale 1ns/1ps
module sgcr_global_ctrl
	import sgcr_pkg::*;
#(
	parameter int FAST_CYCLES = sgcr_pkg::FAST_AGE_CYCLES,
	parameter int MS_TICK     = sgcr_pkg::MS_CYCLES,
	parameter int NORMAL_MS   = sgcr_pkg::NORMAL_AGE_MS
) (
	input  wire logic        core_clk,
	input  wire logic        reset_n,
	input  wire logic        aging_strap_pin,
	input  wire logic        backoff_strap_pin,
	input  wire logic        collision_drop_strap_pin,
	input  wire logic        max_size_strap_pin,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	output logic             regRdValid,
	output logic             strapDone,
	output logic             agingActive,
	output logic             ageStrobe,
	output logic             aggressiveBackoff,
	output logic             bpCarrierSense,
	input  wire logic        fwdReqValid,
	input  wire logic        fwdKnownUnicast,
	input  wire logic        fwdCrossVlan,
	output logic             fwdValid,
	output logic             fwdPermit,
	input  wire logic        dstAddrValid,
	input  wire logic [47:0] dstAddr,
	output logic             stormCount,
	input  wire logic        contention,
	output logic             dropNonFcPort,
	output logic             holdFcPort,
	input  wire logic        colEvent,
	input  wire logic [4:0]  colCount,
	output logic             colRetry,
	output logic             colDrop,
	input  wire logic        rxFrameDone,
	input  wire logic [10:0] rxFrameLen,
	input  wire logic        rxFrameTagged,
	output logic             rxFrameAccept,
	output logic             rxFrameOversize
);
	import sgcr_pkg::*;

	if (FAST_CYCLES < 1 || MS_TICK < 1 || NORMAL_MS < 1) begin : g_bad_param
		$error("sgcr_global_ctrl aging counts must be at least one");
	end

	// Strap capture
	logic [STRAP_COUNT-1:0] strapPins;
	logic [STRAP_COUNT-1:0] strapStable;
	sgcr_strap_state_t      strapState_r;
	sgcr_strap_state_t      strapState_nxt;
	logic [3:0]             settleCnt_r;
	logic [3:0]             settleCnt_nxt;
	logic                   strapLoad;

	assign strapPins[STRAP_AGING]   = aging_strap_pin;
	assign strapPins[STRAP_BACKOFF] = backoff_strap_pin;
	assign strapPins[STRAP_COLDROP] = collision_drop_strap_pin;
	assign strapPins[STRAP_MAXSIZE] = max_size_strap_pin;

	sgcr_strap_sync #(
		.WIDTH(STRAP_COUNT)
	) u_strap_sync (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.pinIn    (strapPins),
		.pullLevel(4'h1),
		.pinStable(strapStable)
	);

	// Wait for the synchroniser to fill before trusting the pins
	always_comb begin
		strapState_nxt = strapState_r;
		settleCnt_nxt  = settleCnt_r;
		strapLoad      = 1'b0;
		case (strapState_r)
			SGCR_SETTLE: begin
				if (settleCnt_r == STRAP_SETTLE_CYCLES) begin
					strapLoad      = 1'b1;
					strapState_nxt = SGCR_RUN;
				end else begin
					settleCnt_nxt = settleCnt_r + 4'h1;
				end
			end
			SGCR_RUN: begin
				strapState_nxt = SGCR_RUN;
			end
			default: begin
				strapState_nxt = SGCR_SETTLE;
				settleCnt_nxt  = 4'h0;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			strapState_r <= SGCR_SETTLE;
			settleCnt_r  <= 4'h0;
		end else begin
			strapState_r <= strapState_nxt;
			settleCnt_r  <= settleCnt_nxt;
		end
	end

	// Register file
	logic [7:0] gc1_r;
	logic [7:0] gc1_nxt;
	logic [7:0] gc2_r;
	logic [7:0] gc2_nxt;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic       rdValid_r;
	logic       strapDone_r;

	function automatic logic [7:0] readMux(input logic [7:0] addr, input logic [7:0] c1,
		input logic [7:0] c2);
		if (addr == GC1_OFFSET) begin
			readMux = c1;
		end else if (addr == GC2_OFFSET) begin
			readMux = c2;
		end else begin
			readMux = 8'h00;
		end
	endfunction

	always_comb begin
		gc1_nxt = gc1_r;
		gc2_nxt = gc2_r;
		if (strapLoad) begin
			gc1_nxt[GC1_AGING_BIT]    = strapStable[STRAP_AGING];
			gc1_nxt[GC1_BACKOFF_BIT]  = strapStable[STRAP_BACKOFF];
			gc2_nxt[GC2_NOCOLDROP_BIT] = strapStable[STRAP_COLDROP];
			gc2_nxt[GC2_LEGALMAX_BIT] = strapStable[STRAP_MAXSIZE];
		end else if (regWrEn && regAddr == GC1_OFFSET) begin
			gc1_nxt = regWrData;
		end else if (regWrEn && regAddr == GC2_OFFSET) begin
			gc2_nxt = regWrData;
		end
		rdData_nxt = regRdEn ? readMux(regAddr, gc1_r, gc2_r) : rdData_r;
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			gc1_r       <= GC1_RESET;
			gc2_r       <= GC2_RESET;
			rdData_r    <= 8'h00;
			rdValid_r   <= 1'b0;
			strapDone_r <= 1'b0;
		end else begin
			gc1_r       <= gc1_nxt;
			gc2_r       <= gc2_nxt;
			rdData_r    <= rdData_nxt;
			rdValid_r   <= regRdEn;
			strapDone_r <= strapDone_r | strapLoad;
		end
	end

	// Aging timer: normal period runs on a millisecond prescale, 300 s does not fit 32 bits
	logic [31:0] fastCnt_r;
	logic [31:0] fastCnt_nxt;
	logic [31:0] msCnt_r;
	logic [31:0] msCnt_nxt;
	logic [31:0] ageMs_r;
	logic [31:0] ageMs_nxt;
	logic        ageStrobe_r;
	logic        ageStrobe_nxt;
	logic        agingEn;
	logic        fastAge;

	assign agingEn = gc1_r[GC1_AGING_BIT];
	assign fastAge = gc1_r[GC1_FASTAGE_BIT];

	always_comb begin
		fastCnt_nxt   = 32'h0;
		msCnt_nxt     = 32'h0;
		ageMs_nxt     = 32'h0;
		ageStrobe_nxt = 1'b0;
		if (!agingEn) begin
			ageStrobe_nxt = 1'b0;
		end else if (fastAge) begin
			if (fastCnt_r == 32'(FAST_CYCLES - 1)) begin
				ageStrobe_nxt = 1'b1;
			end else begin
				fastCnt_nxt = fastCnt_r + 32'h1;
			end
		end else begin
			ageMs_nxt = ageMs_r;
			if (msCnt_r == 32'(MS_TICK - 1)) begin
				if (ageMs_r == 32'(NORMAL_MS - 1)) begin
					ageStrobe_nxt = 1'b1;
					ageMs_nxt     = 32'h0;
				end else begin
					ageMs_nxt = ageMs_r + 32'h1;
				end
			end else begin
				msCnt_nxt = msCnt_r + 32'h1;
			end
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			fastCnt_r   <= 32'h0;
			msCnt_r     <= 32'h0;
			ageMs_r     <= 32'h0;
			ageStrobe_r <= 1'b0;
		end else begin
			fastCnt_r   <= fastCnt_nxt;
			msCnt_r     <= msCnt_nxt;
			ageMs_r     <= ageMs_nxt;
			ageStrobe_r <= ageStrobe_nxt;
		end
	end

	// Forwarding, storm, contention, collision and frame size decisions
	logic        agingActive_r;
	logic        backoff_r;
	logic        bpCs_r;
	logic        fwdValid_r;
	logic        fwdPermit_r;
	logic        fwdPermit_nxt;
	logic        storm_r;
	logic        storm_nxt;
	logic        dropNonFc_r;
	logic        dropNonFc_nxt;
	logic        holdFc_r;
	logic        holdFc_nxt;
	logic        colRetry_r;
	logic        colRetry_nxt;
	logic        colDrop_r;
	logic        colDrop_nxt;
	logic        rxAccept_r;
	logic        rxAccept_nxt;
	logic        rxOver_r;
	logic        rxOver_nxt;
	logic [10:0] maxLen;

	always_comb begin
		if (gc2_r[GC2_HUGE_BIT]) begin
			maxLen = HUGE_MAX_BYTES;
		end else if (gc2_r[GC2_LEGALMAX_BIT]) begin
			maxLen = LEGAL_MAX_BYTES;
		end else begin
			maxLen = rxFrameTagged ? TAGGED_MAX_BYTES : UNTAGGED_MAX_BYTES;
		end
		rxAccept_nxt = rxFrameDone && (rxFrameLen <= maxLen);
		rxOver_nxt   = rxFrameDone && (rxFrameLen > maxLen);

		// Cross-boundary frames pass only as known unicast with discard off
		fwdPermit_nxt = !fwdCrossVlan ||
			(!gc2_r[GC2_VLANDISC_BIT] && fwdKnownUnicast);

		storm_nxt = dstAddrValid && ((&dstAddr) ||
			(!gc2_r[GC2_STORMDIS_BIT] && dstAddr[40]));

		dropNonFc_nxt = contention && gc2_r[GC2_FAIR_BIT];
		holdFc_nxt    = contention && !gc2_r[GC2_FAIR_BIT];

		colRetry_nxt = colEvent && (colCount >= EXCESS_COL_LIMIT)
			&& gc2_r[GC2_NOCOLDROP_BIT];
		colDrop_nxt  = colEvent && (colCount >= EXCESS_COL_LIMIT)
			&& !gc2_r[GC2_NOCOLDROP_BIT];
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			agingActive_r <= 1'b0;
			backoff_r     <= 1'b0;
			bpCs_r        <= 1'b0;
			fwdValid_r    <= 1'b0;
			fwdPermit_r   <= 1'b0;
			storm_r       <= 1'b0;
			dropNonFc_r   <= 1'b0;
			holdFc_r      <= 1'b0;
			colRetry_r    <= 1'b0;
			colDrop_r     <= 1'b0;
			rxAccept_r    <= 1'b0;
			rxOver_r      <= 1'b0;
		end else begin
			agingActive_r <= agingEn;
			backoff_r     <= gc1_r[GC1_BACKOFF_BIT];
			bpCs_r        <= gc2_r[GC2_BPMODE_BIT];
			fwdValid_r    <= fwdReqValid;
			fwdPermit_r   <= fwdReqValid && fwdPermit_nxt;
			storm_r       <= storm_nxt;
			dropNonFc_r   <= dropNonFc_nxt;
			holdFc_r      <= holdFc_nxt;
			colRetry_r    <= colRetry_nxt;
			colDrop_r     <= colDrop_nxt;
			rxAccept_r    <= rxAccept_nxt;
			rxOver_r      <= rxOver_nxt;
		end
	end

	assign regRdData         = rdData_r;
	assign regRdValid        = rdValid_r;
	assign strapDone         = strapDone_r;
	assign agingActive       = agingActive_r;
	assign ageStrobe         = ageStrobe_r;
	assign aggressiveBackoff = backoff_r;
	assign bpCarrierSense    = bpCs_r;
	assign fwdValid          = fwdValid_r;
	assign fwdPermit         = fwdPermit_r;
	assign stormCount        = storm_r;
	assign dropNonFcPort     = dropNonFc_r;
	assign holdFcPort        = holdFc_r;
	assign colRetry          = colRetry_r;
	assign colDrop           = colDrop_r;
	assign rxFrameAccept     = rxAccept_r;
	assign rxFrameOversize   = rxOver_r;
endmodule // sgcr_global_ctrl

// ===== core/sgcr_strap_sync.sv
`timescale 1ns/1ps
module sgcr_strap_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             core_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] pinIn,
	input  wire logic [WIDTH-1:0] pullLevel,
	output logic      [WIDTH-1:0] pinStable
);
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;
	logic [WIDTH-1:0] stage3_r;
	logic [WIDTH-1:0] stable_r;
	logic [WIDTH-1:0] stable_nxt;

	if (WIDTH < 1) begin : g_bad_width
		$error("sgcr_strap_sync needs WIDTH of at least one");
	end

	// Stable value only moves when the last two stages agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			stable_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i] : stable_r[i];
		end
	end

	// Pull level is not used: reset clears every stage and the stable value to zero, not to the pull level
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1_r <= '0;
			stage2_r <= '0;
			stage3_r <= '0;
			stable_r <= '0;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
			stage3_r <= stage2_r;
			stable_r <= stable_nxt;
		end
	end

	assign pinStable = stable_r;
endmodule // sgcr_strap_sync

// ===== verification/sgcr_ctrl_props.sv
`timescale 1ns/1ps
module sgcr_ctrl_props (
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic        regRdEn,
	input wire logic        regRdValid,
	input wire logic        strapDone,
	input wire logic        agingActive,
	input wire logic        ageStrobe,
	input wire logic        fwdReqValid,
	input wire logic        fwdKnownUnicast,
	input wire logic        fwdCrossVlan,
	input wire logic        fwdValid,
	input wire logic        fwdPermit,
	input wire logic        dstAddrValid,
	input wire logic [47:0] dstAddr,
	input wire logic        stormCount,
	input wire logic        contention,
	input wire logic        dropNonFcPort,
	input wire logic        holdFcPort,
	input wire logic        colEvent,
	input wire logic [4:0]  colCount,
	input wire logic        colRetry,
	input wire logic        colDrop,
	input wire logic        rxFrameDone,
	input wire logic [10:0] rxFrameLen,
	input wire logic        rxFrameAccept,
	input wire logic        rxFrameOversize
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	rd_answer_a: assert property (strapDone && regRdEn |=> regRdValid)
		else $error("read not answered");
	local_fwd_a: assert property (fwdReqValid && !fwdCrossVlan |=> fwdValid && fwdPermit)
		else $error("local frame refused");
	unknown_kept_a: assert property (fwdReqValid && fwdCrossVlan && !fwdKnownUnicast
		|=> fwdValid && !fwdPermit)
		else $error("unknown frame crossed");
	bcast_counted_a: assert property (dstAddrValid && &dstAddr |=> stormCount)
		else $error("broadcast not counted");
	plain_free_a: assert property (dstAddrValid && !dstAddr[40] |=> !stormCount)
		else $error("plain frame counted");
	huge_limit_a: assert property (rxFrameDone && rxFrameLen > 11'h77c
		|=> rxFrameOversize && !rxFrameAccept)
		else $error("too long frame kept");
	small_frame_a: assert property (rxFrameDone && rxFrameLen <= 11'h5ee
		|=> rxFrameAccept && !rxFrameOversize)
		else $error("short frame lost");
	excess_col_a: assert property (colEvent && colCount >= 5'h10 |=> colRetry != colDrop)
		else $error("excess collision unresolved");
	fair_one_a: assert property ((dropNonFcPort || holdFcPort) == $past(contention)
		&& !(dropNonFcPort && holdFcPort))
		else $error("contention answer wrong");
	age_gated_a: assert property (ageStrobe |-> agingActive || $past(agingActive))
		else $error("aging while disabled");
endmodule // sgcr_ctrl_props

bind sgcr_global_ctrl sgcr_ctrl_props u_props (.*);

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import sgcr_pkg::*;
	logic core_clk = '0, reset_n = '0, regWrEn = '0, regRdEn = '0;
	logic aging_strap_pin = '0, backoff_strap_pin = '0;
	logic collision_drop_strap_pin = '0, max_size_strap_pin = '0;
	logic [7:0] regAddr = '0, regWrData = '0, regRdData;
	logic regRdValid, strapDone, agingActive, ageStrobe, aggressiveBackoff, bpCarrierSense;
	logic fwdReqValid = '0, fwdKnownUnicast = '0, fwdCrossVlan = '0, fwdValid, fwdPermit;
	logic dstAddrValid = '0, stormCount, contention = '0, dropNonFcPort, holdFcPort;
	logic colEvent = '0, colRetry, colDrop, rxFrameDone = '0, rxFrameTagged = '0;
	logic rxFrameAccept, rxFrameOversize;
	logic [47:0] dstAddr = '0;
	logic [4:0]  colCount = '0;
	logic [10:0] rxFrameLen = '0;
	int n_errors = 0;
	int total_checks = 0;

	always #12.5 core_clk = ~core_clk;

	// Short aging counts keep the run brief
	sgcr_global_ctrl #(.FAST_CYCLES(4), .MS_TICK(3), .NORMAL_MS(2)) u_dut (.*);

	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic do_reset(input logic [3:0] s);
		int i;
		@(posedge core_clk);
		reset_n <= 1'b0;
		{max_size_strap_pin, collision_drop_strap_pin, backoff_strap_pin, aging_strap_pin} <= s;
		repeat (10) @(posedge core_clk);
		reset_n <= 1'b1;
		for (i = 0; i < 20 && strapDone !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (strapDone !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t strap load timed out", $time);
			report_and_stop;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge core_clk);
		regWrEn <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge core_clk);
		regRdEn <= 1'b0;
		#1;
		chk({7'h00, regRdValid}, 8'h01);
		chk(regRdData, exp);
	endtask

	task automatic t_straps;
		do_reset(4'h1);
		rd(8'h03, 8'h04);
		rd(8'h04, 8'hf0);
		chk({5'h00, aggressiveBackoff, bpCarrierSense, agingActive}, 8'h03);
		do_reset(4'he);
		rd(8'h03, 8'h01);
		rd(8'h04, 8'hfa);
		chk({5'h00, aggressiveBackoff, bpCarrierSense, agingActive}, 8'h06);
		rd(8'h05, 8'h00);
		$display("test straps done");
	endtask

	task automatic t_rw;
		wr(8'h03, 8'ha6);
		wr(8'h04, 8'h55);
		rd(8'h03, 8'ha6);
		rd(8'h04, 8'h55);
		chk({5'h00, aggressiveBackoff, bpCarrierSense, agingActive}, 8'h01);
		$display("test readback done");
	endtask

	// One cycle fires four of the five decision paths at once, all but contention
	task automatic cs(input logic [7:0] g, input logic [1:0] fw, input logic [1:0] d,
		input logic [4:0] cc, input logic [10:0] len, input logic tg, input logic [7:0] exp);
		wr(8'h04, g);
		@(posedge core_clk);
		{fwdReqValid, dstAddrValid, colEvent, rxFrameDone} <= 4'hf;
		{fwdKnownUnicast, fwdCrossVlan} <= fw;
		dstAddr <= {7'h00, d[0], 40'h0} | {48{d[1]}};
		colCount <= cc;
		rxFrameLen <= len;
		rxFrameTagged <= tg;
		@(posedge core_clk);
		{fwdReqValid, dstAddrValid, colEvent, rxFrameDone} <= 4'h0;
		#1;
		chk({fwdValid, fwdPermit, stormCount, colRetry, colDrop, rxFrameAccept,
			rxFrameOversize, 1'b0}, exp);
	endtask

	task automatic t_dec;
		cs(8'hf0, 2'h3, 2'h1, 5'h10, 11'h5ee, 1'b0, 8'h8c);
		cs(8'h0c, 2'h3, 2'h1, 5'h10, 11'h77c, 1'b0, 8'hf4);
		cs(8'h0c, 2'h1, 2'h2, 5'h1f, 11'h77d, 1'b0, 8'hb2);
		cs(8'h06, 2'h0, 2'h0, 5'h10, 11'h77c, 1'b1, 8'hcc);
		cs(8'h02, 2'h0, 2'h2, 5'h10, 11'h600, 1'b0, 8'hec);
		cs(8'h02, 2'h0, 2'h0, 5'h10, 11'h601, 1'b0, 8'hca);
		cs(8'h00, 2'h0, 2'h2, 5'h10, 11'h5f2, 1'b1, 8'hec);
		cs(8'h00, 2'h0, 2'h0, 5'h10, 11'h5f3, 1'b1, 8'hca);
		cs(8'h00, 2'h0, 2'h0, 5'h10, 11'h5ef, 1'b0, 8'hca);
		cs(8'h40, 2'h0, 2'h2, 5'h10, 11'h5ee, 1'b0, 8'hec);
		$display("test decisions done");
	endtask

	task automatic t_fair;
		wr(8'h04, 8'h10);
		contention <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1;
		chk({6'h00, dropNonFcPort, holdFcPort}, 8'h02);
		wr(8'h04, 8'h00);
		@(posedge core_clk);
		#1;
		chk({6'h00, dropNonFcPort, holdFcPort}, 8'h01);
		@(posedge core_clk);
		contention <= 1'b0;
		$display("test fairness done");
	endtask

	// Measures the spacing of two strobes after the first is seen
	task automatic t_age(input logic [7:0] g, input logic [7:0] period);
		int i;
		logic [7:0] n;
		wr(8'h03, g);
		// Look after the write edge has settled, not in its own time step
		#1;
		for (i = 0; i < 40 && ageStrobe !== 1'b1; i++) begin
			@(posedge core_clk);
			#1;
		end
		if (ageStrobe !== 1'b1) begin
			n_errors++;
			$display("ERROR %0t aging strobe timed out", $time);
			report_and_stop;
		end
		n = 8'h00;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (ageStrobe !== 1'b1 && n < 8'h28);
		chk(n, period);
		$display("test aging done");
	endtask

	task automatic t_age_off;
		logic [7:0] n;
		wr(8'h03, 8'h00);
		repeat (2) @(posedge core_clk);
		n = 8'h00;
		repeat (20) begin
			@(posedge core_clk);
			#1;
			n = n + ageStrobe;
		end
		chk(n, 8'h00);
		$display("test aging off done");
	endtask

	initial begin
		t_straps;
		t_rw;
		t_dec;
		t_fair;
		t_age(8'h06, 8'h04);
		t_age(8'h04, 8'h06);
		t_age_off;
		report_and_stop;
	end
endmodule // tb_top
